// file: ssp_regs.vh
// Constants for the synchronous serial port block
// Contract
// - Client shifts on each serial clock pulse; flag set after last bit latched.
// - Client shift register runs on serial clock; eight bits set flag, wake.
// - Host mode sleep halts clocks and freezes transfer; resumes on wake.
// - Daisy-chain client outputs next group exactly the bits previously received.
// - Overwrite enable lets a new byte replace an unread buffer byte.
// - Mode select 0100 is client with select pin control.
// - Select low enables transmit, receive and drives data output.
// - Select high releases data output at once, even mid byte.
// - Port reset clears bit counter: select high or enable cleared.
// - I2C start is SDA falling while SCL high, then address.
// - Bytes go MSB first; address followed by read/write direction bit.
// - Addressed client acknowledges by pulling SDA low.
// - SDA changes only while SCL low except start and stop.
// - Stop is SDA rising with SCL high; receiving host skips final ack.
// - Host may repeat start instead of stop or final ack.
// - Receiver acknowledges each byte in writes, and all but the last byte in reads.
// - Address register is own address under mask, or host reload value.
// - Receive double buffered; transmit write loads buffer and shift register.
// - Status low six bits read only, upper two writable; controls writable.
// - Edge setting set: data changes active-to-idle; clear: idle-to-active.
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
`define SSP_MODE_SPI_HOST_DIV4  4'h0
`define SSP_MODE_SPI_CLIENT_SS  4'h4
`define SSP_MODE_SPI_CLIENT     4'h5
`define SSP_MODE_I2C_CLIENT7    4'h6
`define SSP_BITS_PER_BYTE       4'h8
`define SSP_STAT_RO_MASK        8'h3f
`define SSP_STAT_RW_MASK        8'hc0
`define SSP_RESET_BYTE          8'h00
`define SSP_FIFO_DEPTH          8
`endif

// file: ssp_fifo.v
// Small synchronous FIFO for received bytes
`timescale 1ns/100ps
module ssp_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             mclk,
   input  wire             rst_n,
   input  wire             clr,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output reg  [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_q;
   reg [AW:0]      rd_q;
   wire            full;
   wire            empty;
   wire            push;
   wire            pop;

   assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign empty     = (wr_q == rd_q);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;

   always @(posedge mclk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always @* begin
      out_data = mem[rd_q[AW-1:0]];
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
      end else if (clr) begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

// file: ssp_core.v
// Serial port core: SPI client/host and I2C client
`timescale 1ns/100ps
`include "ssp_regs.vh"
module ssp_core #(
   parameter FIFO_DEPTH = `SSP_FIFO_DEPTH,
   parameter FIFO_AW    = 3
) (
   // Clock and reset
   input  wire       mclk,
   input  wire       rst_n,
   // Configuration
   input  wire       port_enable,
   input  wire [3:0] port_mode_select,
   input  wire       clk_polarity_sel,
   input  wire       clk_edge_sel,
   input  wire       input_sample_pos,
   input  wire       buffer_overwrite_en,
   input  wire       sleep_req,
   input  wire [7:0] address_or_reload,
   input  wire [7:0] client_address_mask,
   input  wire [1:0] status_wr_data,
   input  wire       status_wr,
   // Data buffer access
   input  wire       tx_write,
   input  wire [7:0] tx_data,
   input  wire       rx_read,
   output reg  [7:0] data_buffer,
   output wire       rx_valid,
   output wire [7:0] rx_fifo_data,
   output reg        buffer_full,
   output reg        write_collision,
   output reg        receive_overflow,
   output reg        port_irq_flag,
   input  wire       irq_clear,
   output wire [7:0] port_status_reg,
   // SPI pins
   input  wire       sck_in,
   output reg        sck_out,
   output wire       sck_oe,
   input  wire       sdi_in,
   output wire       sdo_out,
   output wire       sdo_oe,
   input  wire       ss_n_in,
   // I2C pins
   input  wire       scl_in,
   output wire       scl_out,
   output wire       scl_oe,
   input  wire       sda_in,
   output wire       sda_out,
   output reg        sda_oe,
   output reg        addr_match
);
   // I2C client states
   localparam [4:0] I_IDLE = 5'h01;
   localparam [4:0] I_ADDR = 5'h02;
   localparam [4:0] I_ACK  = 5'h04;
   localparam [4:0] I_DATA = 5'h08;
   localparam [4:0] I_SEND = 5'h10;

   reg  [7:0] shift_register;
   reg  [3:0] bit_cnt_q;
   reg        sck_q;
   reg        scl_q;
   reg        sda_q;
   reg        sdo_q;
   reg        host_busy_q;
   reg  [1:0] div_q;
   reg  [1:0] stat_hi_q;
   reg  [4:0] i2c_st_q;
   reg        i2c_read_q;
   reg        ack_drive_q;
   reg  [7:0] rx_byte;
   reg        rx_done;
   wire       is_host;
   wire       is_client;
   wire       is_i2c;
   wire       ss_ctl;
   wire       port_rst;
   wire       sck_act;
   wire       sck_idle_edge;
   wire       sck_act_edge;
   wire       sample_edge;
   wire       shift_edge;
   wire       selected;
   wire       scl_rise;
   wire       scl_fall;
   wire       i2c_start;
   wire       i2c_stop;
   wire       fifo_in_ready;
   wire       busy;
   wire       tx_load;

   function addr_hit;
      input [7:0] rx;
      input [7:0] own;
      input [7:0] msk;
      begin
         addr_hit = ((rx[7:1] ^ own[7:1]) & msk[7:1]) == 7'h00;
      end
   endfunction

   assign is_host   = port_mode_select[3:2] == 2'b00;
   assign ss_ctl    = port_mode_select == `SSP_MODE_SPI_CLIENT_SS;
   assign is_client = ss_ctl || port_mode_select == `SSP_MODE_SPI_CLIENT;
   assign is_i2c    = port_mode_select == `SSP_MODE_I2C_CLIENT7;
   assign port_rst  = !port_enable || (ss_ctl && ss_n_in);
   assign selected  = !ss_ctl || !ss_n_in;

   // Active clock level relative to idle polarity
   assign sck_act       = sck_in ^ clk_polarity_sel;
   assign sck_act_edge  = sck_act && !sck_q;
   assign sck_idle_edge = !sck_act && sck_q;
   // Edge setting picks which transition launches data
   assign shift_edge  = clk_edge_sel ? sck_idle_edge : sck_act_edge;
   assign sample_edge = clk_edge_sel ? sck_act_edge : sck_idle_edge;

   assign sdo_out = sdo_q;
   assign sdo_oe  = port_enable && !is_i2c && selected;
   assign sck_oe  = port_enable && is_host;
   assign busy    = bit_cnt_q != 4'h0 || host_busy_q;
   assign tx_load = tx_write && port_enable && (port_rst || !busy);

   assign scl_rise  = scl_in && !scl_q;
   assign scl_fall  = !scl_in && scl_q;
   assign i2c_start = scl_in && scl_q && sda_q && !sda_in;
   assign i2c_stop  = scl_in && scl_q && !sda_q && sda_in;
   assign scl_out   = 1'b0;
   assign scl_oe    = 1'b0;
   assign sda_out   = 1'b0;

   assign port_status_reg = {stat_hi_q, 5'h00, buffer_full} & 8'hff;

   // Pin history and host clock
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sck_q   <= 1'b0;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         sck_out <= 1'b0;
         div_q   <= 2'h0;
      end else begin
         if (!(is_host && sleep_req)) begin
            sck_q <= sck_act;
         end
         scl_q <= scl_in;
         sda_q <= sda_in;
         if (!port_enable || !is_host) begin
            sck_out <= clk_polarity_sel;
            div_q   <= 2'h0;
         end else if (host_busy_q && !sleep_req) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
               sck_out <= !sck_out;
            end
         end else if (!host_busy_q) begin
            sck_out <= clk_polarity_sel;
         end
      end
   end

   // Software status bits: only the upper two are writable
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stat_hi_q <= 2'h0;
      end else if (status_wr) begin
         stat_hi_q <= status_wr_data;
      end
   end

   // SPI shifter, bit counter and I2C client sequencing
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_register  <= `SSP_RESET_BYTE;
         bit_cnt_q       <= 4'h0;
         sdo_q           <= 1'b0;
         host_busy_q     <= 1'b0;
         write_collision <= 1'b0;
         rx_done         <= 1'b0;
         rx_byte         <= `SSP_RESET_BYTE;
         i2c_st_q        <= I_IDLE;
         i2c_read_q      <= 1'b0;
         ack_drive_q     <= 1'b0;
         sda_oe          <= 1'b0;
         addr_match      <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (tx_write && !tx_load && port_enable) begin
            write_collision <= 1'b1;
         end
         if (port_rst) begin
            bit_cnt_q   <= 4'h0;
            host_busy_q <= 1'b0;
            i2c_st_q    <= I_IDLE;
            sda_oe      <= 1'b0;
            addr_match  <= 1'b0;
            // Client preloads its reply while deselected
            if (tx_load) begin
               shift_register <= tx_data;
               sdo_q          <= tx_data[7];
            end
         end else if (tx_load) begin
            shift_register <= tx_data;
            sdo_q          <= tx_data[7];
            host_busy_q    <= is_host;
         end else if (is_i2c) begin
            case (i2c_st_q)
               I_IDLE: begin
                  sda_oe <= 1'b0;
               end
               I_ADDR, I_DATA: begin
                  if (scl_rise) begin
                     shift_register <= {shift_register[6:0], sda_in};
                     bit_cnt_q      <= bit_cnt_q + 4'h1;
                  end else if (scl_fall && bit_cnt_q == `SSP_BITS_PER_BYTE) begin
                     bit_cnt_q <= 4'h0;
                     if (i2c_st_q == I_DATA) begin
                        rx_byte <= shift_register;
                        rx_done <= 1'b1;
                        sda_oe  <= 1'b1;
                        i2c_st_q <= I_ACK;
                     end else if (addr_hit(shift_register, address_or_reload,
                                           client_address_mask)) begin
                        addr_match <= 1'b1;
                        i2c_read_q <= shift_register[0];
                        sda_oe     <= 1'b1;
                        i2c_st_q   <= I_ACK;
                     end else begin
                        i2c_st_q <= I_IDLE;
                     end
                  end
               end
               I_ACK: begin
                  if (scl_fall) begin
                     sda_oe   <= i2c_read_q && !shift_register[7];
                     i2c_st_q <= i2c_read_q ? I_SEND : I_DATA;
                  end
               end
               I_SEND: begin
                  if (scl_rise) begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt_q == `SSP_BITS_PER_BYTE) begin
                        sda_oe   <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        i2c_st_q <= I_ACK;
                     end else begin
                        shift_register <= {shift_register[6:0], 1'b1};
                        sda_oe         <= !shift_register[6];
                     end
                  end
               end
               default: begin
                  i2c_st_q <= I_IDLE;
               end
            endcase
            // Host ack low keeps a read going; high ends it
            if (i2c_st_q == I_ACK && i2c_read_q && scl_rise && sda_in) begin
               i2c_st_q <= I_IDLE;
            end
            if (i2c_start) begin
               i2c_st_q   <= I_ADDR;
               bit_cnt_q  <= 4'h0;
               sda_oe     <= 1'b0;
               addr_match <= 1'b0;
            end else if (i2c_stop) begin
               i2c_st_q   <= I_IDLE;
               sda_oe     <= 1'b0;
               addr_match <= 1'b0;
            end
         end else if ((is_client && selected) || (is_host && host_busy_q && !sleep_req)) begin
            if (sample_edge) begin
               shift_register <= {shift_register[6:0], sdi_in};
               if (bit_cnt_q == `SSP_BITS_PER_BYTE - 4'h1) begin
                  bit_cnt_q   <= 4'h0;
                  rx_byte     <= {shift_register[6:0], sdi_in};
                  rx_done     <= 1'b1;
                  host_busy_q <= 1'b0;
               end else begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
            end
            // With edge setting set, last edge of a byte already shows the received MSB
            if (shift_edge) begin
               sdo_q <= shift_register[7];
            end
         end
      end
   end

   // Receive buffer, flags; hardware set wins over clear
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         data_buffer      <= `SSP_RESET_BYTE;
         buffer_full      <= 1'b0;
         receive_overflow <= 1'b0;
         port_irq_flag    <= 1'b0;
      end else begin
         if (rx_read) begin
            buffer_full <= 1'b0;
         end
         if (irq_clear) begin
            port_irq_flag <= 1'b0;
         end
         if (tx_load) begin
            data_buffer <= tx_data;
         end
         if (rx_done) begin
            port_irq_flag <= 1'b1;
            if (!buffer_full || buffer_overwrite_en || rx_read) begin
               data_buffer <= rx_byte;
               buffer_full <= 1'b1;
            end else begin
               receive_overflow <= 1'b1;
            end
         end
      end
   end

   // Received byte stream for downstream consumers
   ssp_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .clr       (!port_enable),
      .in_valid  (rx_done),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_byte),
      .out_valid (rx_valid),
      .out_ready (rx_read),
      .out_data  (rx_fifo_data)
   );
endmodule

// file: ssp_core_sva.sv
// Concurrent checks on the serial port core ports
`timescale 1ns/100ps
module ssp_core_sva (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rst_n,
   // Controls
   input wire logic       port_enable,
   input wire logic [3:0] port_mode_select,
   input wire logic       sleep_req,
   input wire logic       status_wr,
   input wire logic [1:0] status_wr_data,
   input wire logic       irq_clear,
   input wire logic       rx_read,
   // Status
   input wire logic       port_irq_flag,
   input wire logic       buffer_full,
   input wire logic       write_collision,
   input wire logic [7:0] port_status_reg,
   // Pins
   input wire logic       sck_out,
   input wire logic       sdo_oe,
   input wire logic       ss_n_in,
   input wire logic       scl_in,
   input wire logic       sda_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_sdo_float: assert property (port_enable && port_mode_select == 4'h4 && ss_n_in |-> !sdo_oe)
      else $error("data output driven while deselected");
   a_sdo_drive: assert property (port_enable && port_mode_select == 4'h4 && !ss_n_in |-> ##[0:2] sdo_oe)
      else $error("data output not driven while selected");
   a_irq_full: assert property ($rose(port_irq_flag) |-> ##[0:1] buffer_full)
      else $error("flag raised without buffer full");
   a_irq_sticky: assert property (port_enable && port_irq_flag && !irq_clear && !rx_read |=> port_irq_flag)
      else $error("flag dropped without clear");
   a_wcol_sticky: assert property (write_collision |=> write_collision)
      else $error("collision flag dropped");
   a_status_low: assert property (port_status_reg[5:0] == {5'h00, buffer_full})
      else $error("status low bits wrong");
   a_status_write: assert property (status_wr |=> port_status_reg[7:6] == $past(status_wr_data))
      else $error("status upper bits not written");
   a_sleep_hold: assert property (port_enable && port_mode_select == 4'h0 && sleep_req && $past(sleep_req)
      && $past(sleep_req, 2) |-> $stable(sck_out))
      else $error("host clock moved during sleep");
   a_sda_low_scl: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data line changed with clock high");
endmodule

bind ssp_core ssp_core_sva u_sva (.mclk, .rst_n, .port_enable, .port_mode_select, .sleep_req,
   .status_wr, .status_wr_data, .irq_clear, .rx_read, .port_irq_flag, .buffer_full,
   .write_collision, .port_status_reg, .sck_out, .sdo_oe, .ss_n_in, .scl_in, .sda_oe);

// file: ssp_spi_host_model.sv
// SPI host partner driving the client pins
`timescale 1ns/100ps
module ssp_spi_host_model (
   // Clock and returned data
   input  wire logic mclk,
   input  wire logic cpol,
   input  wire logic miso,
   // Driven pins
   output logic      sck,
   output logic      mosi,
   output logic      ss_n
);
   initial begin
      sck = 1'b0;
      mosi = 1'b1;
      ss_n = 1'b1;
   end
   task park;
      sck = cpol;
   endtask
   // Framed burst, MSB first, data set well before the active edge
   task automatic xfer(input logic [7:0] d, input int nb, output logic [7:0] q);
      q = 8'h00;
      @(negedge mclk);
      ss_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         repeat (4) @(negedge mclk);
         mosi = d[7-i];
         repeat (4) @(negedge mclk);
         q = {q[6:0], miso};
         sck = ~cpol;
         repeat (4) @(negedge mclk);
         sck = cpol;
      end
      repeat (4) @(negedge mclk);
      ss_n = 1'b1;
      mosi = ~mosi;
   endtask
endmodule

// file: ssp_core_tb.sv
// Self-checking bench for the serial port core
`timescale 1ns/100ps
module ssp_core_tb;
   logic       mclk, rst_n, port_enable, clk_polarity_sel, buffer_overwrite_en, sleep_req;
   logic       status_wr, tx_write, rx_read, irq_clear, scl_d, sda_d, last_sdo;
   logic       clk_edge_sel, input_sample_pos;
   logic [3:0] port_mode_select;
   logic [1:0] status_wr_data;
   logic [7:0] address_or_reload, client_address_mask, tx_data, q;
   wire  [7:0] data_buffer, rx_fifo_data, port_status_reg;
   wire        rx_valid, buffer_full, write_collision, receive_overflow, port_irq_flag;
   wire        sck_out, sck_oe, sdo_out, sdo_oe, sda_oe, h_sck, h_mosi, ss_n_in;
   wire        addr_match, scl_out, scl_oe, sda_out;
   int         error_cnt, checked;
   wire        sck_in = sck_oe ? sck_out : h_sck;
   wire        sdi_in = (port_mode_select == 4'h0) ? sdo_out : h_mosi;
   wire        sdo_line = sdo_oe ? sdo_out : ~last_sdo;
   wire        scl_in = scl_d;
   wire        sda_in = sda_d & ~sda_oe;

   ssp_core dut (.mclk, .rst_n, .port_enable, .port_mode_select, .clk_polarity_sel,
      .clk_edge_sel, .input_sample_pos, .buffer_overwrite_en, .sleep_req, .address_or_reload,
      .client_address_mask, .status_wr_data, .status_wr, .tx_write, .tx_data, .rx_read,
      .data_buffer, .rx_valid, .rx_fifo_data, .buffer_full, .write_collision,
      .receive_overflow, .port_irq_flag, .irq_clear, .port_status_reg, .sck_in, .sck_out,
      .sck_oe, .sdi_in, .sdo_out, .sdo_oe, .ss_n_in, .scl_in, .scl_out, .scl_oe, .sda_in,
      .sda_out, .sda_oe, .addr_match);
   ssp_spi_host_model host (.mclk(mclk), .cpol(clk_polarity_sel), .miso(sdo_line),
      .sck(h_sck), .mosi(h_mosi), .ss_n(ss_n_in));

   always #5 mclk = ~mclk;
   // Released data line shows the inverse of its last driven level
   always @(posedge mclk) if (sdo_oe) last_sdo <= sdo_out;

   task check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task summarize;
      if (error_cnt == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task cfg(input logic [3:0] m, input logic cp, input logic ow);
      @(negedge mclk);
      port_enable = 1'b0;
      port_mode_select = m;
      clk_polarity_sel = cp;
      buffer_overwrite_en = ow;
      irq_clear = 1'b1;
      rx_read = 1'b1;
      clk_edge_sel = (m != 4'h5);
      repeat (2) @(negedge mclk);
      irq_clear = 1'b0;
      rx_read = 1'b0;
      host.park();
      @(negedge mclk);
      port_enable = 1'b1;
   endtask
   task wait_irq;
      int n;
      n = 0;
      while (port_irq_flag !== 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
      check(8'(port_irq_flag), 8'h01);
   endtask
   task drain(output int cnt, output logic [7:0] first);
      cnt = 0;
      first = 8'h00;
      while (rx_valid === 1'b1 && cnt < 20) begin
         if (cnt == 0) first = rx_fifo_data;
         rx_read = 1'b1;
         @(negedge mclk);
         rx_read = 1'b0;
         @(negedge mclk);
         cnt++;
      end
   endtask
   task send_tx(input logic [7:0] d);
      tx_data = d;
      tx_write = 1'b1;
      @(negedge mclk);
      tx_write = 1'b0;
   endtask

   task t_status;
      @(negedge mclk);
      status_wr_data = 2'b11;
      status_wr = 1'b1;
      @(negedge mclk);
      status_wr = 1'b0;
      check({6'h00, port_status_reg[7:6]}, 8'h03);
      check({2'b00, port_status_reg[5:0]}, 8'h00);
   endtask
   task t_spi;
      cfg(4'h4, 1'b0, 1'b1);
      send_tx(8'ha5);
      host.xfer(8'h3c, 8, q);
      wait_irq();
      check(q, 8'ha5);
      check(data_buffer, 8'h3c);
      host.xfer(8'h5a, 8, q);
      check(q, 8'h3c);
      check(data_buffer, 8'h5a);
   endtask
   task t_abort;
      int n;
      logic [7:0] f;
      cfg(4'h4, 1'b1, 1'b0);
      drain(n, f);
      host.xfer(8'hff, 3, q);
      #1;
      check(8'(sdo_oe), 8'h00);
      host.xfer(8'h96, 8, q);
      wait_irq();
      check(data_buffer, 8'h96);
   endtask
   task t_fifo;
      int n;
      logic [7:0] f;
      cfg(4'h4, 1'b0, 1'b0);
      drain(n, f);
      for (int i = 0; i < 9; i++) begin
         host.xfer(8'h10 + 8'(i), 8, q);
      end
      check(8'(receive_overflow), 8'h01);
      drain(n, f);
      check(8'(n), 8'h08);
      check(f, 8'h10);
   endtask
   task t_sleep;
      logic s;
      cfg(4'h0, 1'b0, 1'b0);
      send_tx(8'hc3);
      check(8'(write_collision), 8'h00);
      repeat (20) @(negedge mclk);
      sleep_req = 1'b1;
      repeat (3) @(negedge mclk);
      s = sck_out;
      send_tx(8'h55);
      check(8'(write_collision), 8'h01);
      repeat (100) @(negedge mclk);
      check(8'(sck_out), 8'(s));
      check(8'(port_irq_flag), 8'h00);
      sleep_req = 1'b0;
      wait_irq();
      check(data_buffer, 8'hc3);
   endtask
   task i2c_bit(input logic b);
      sda_d = b;
      repeat (4) @(negedge mclk);
      scl_d = 1'b1;
      repeat (4) @(negedge mclk);
      scl_d = 1'b0;
      repeat (2) @(negedge mclk);
   endtask
   task t_mode5;
      cfg(4'h5, 1'b0, 1'b1);
      host.xfer(8'h69, 8, q);
      wait_irq();
      check(data_buffer, 8'h69);
   endtask
   task t_i2c(input logic [7:0] a, input logic ack);
      logic [7:0] d;
      d = 8'h5c;
      cfg(4'h6, 1'b0, 1'b0);
      sda_d = 1'b0;
      repeat (4) @(negedge mclk);
      scl_d = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         i2c_bit(a[i]);
      end
      sda_d = 1'b1;
      repeat (4) @(negedge mclk);
      check(8'(sda_oe), 8'(ack));
      check(8'(addr_match), 8'(ack));
      i2c_bit(1'b1);
      for (int i = 7; i >= 0; i--) begin
         i2c_bit(d[i]);
      end
      sda_d = 1'b1;
      repeat (4) @(negedge mclk);
      check(8'(sda_oe), 8'(ack));
      check(8'(port_irq_flag), 8'(ack));
      check(data_buffer, 8'h5c);
      check({5'h00, scl_oe, scl_out, sda_out}, 8'h00);
      i2c_bit(1'b1);
      i2c_bit(1'b0);
      scl_d = 1'b1;
      repeat (4) @(negedge mclk);
      sda_d = 1'b1;
      repeat (4) @(negedge mclk);
   endtask

   initial begin
      {mclk, rst_n, port_enable, clk_polarity_sel, buffer_overwrite_en, sleep_req} = '0;
      {status_wr, tx_write, rx_read, irq_clear, last_sdo, input_sample_pos} = '0;
      {scl_d, sda_d, clk_edge_sel} = 3'b111;
      port_mode_select = 4'h4;
      status_wr_data = 2'b00;
      address_or_reload = 8'ha0;
      client_address_mask = 8'hfe;
      tx_data = 8'h00;
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      t_status();
      t_spi();
      t_abort();
      t_fifo();
      t_mode5();
      t_sleep();
      t_i2c(8'ha0, 1'b1);
      t_i2c(8'ha2, 1'b0);
      summarize();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      summarize();
   end
endmodule
